// *** pd_rst_pkg.sv ***
// Constants for the power-down and reset control block
//------------------------------------------------------------
//------------------------------------------------------------
package pd_rst_pkg;
    localparam int ADDR_W = 6;
    localparam int NPIN = 8;
    // Register offsets
    localparam logic [5:0] CTRL_OFS = 6'h00;
    localparam logic [5:0] RPWR_OFS = 6'h04;
    localparam logic [5:0] SLEW_OFS = 6'h08;
    localparam logic [5:0] OE_OFS = 6'h0C;
    localparam logic [5:0] SIG_OFS = 6'h10;
    localparam logic [5:0] FUSE_OFS = 6'h14;
    localparam logic [5:0] STAT_OFS = 6'h18;
    localparam logic [5:0] MCELL_OFS = 6'h1C;
    localparam logic [5:0] CFG_OFS = 6'h20;
    // Control fields
    localparam int CTRL_PD_EN = 0;
    localparam int CTRL_SB_EN = 1;
    localparam int CTRL_KEEP_EN = 2;
    // Status fields
    localparam int STAT_PD = 0;
    localparam int STAT_SB = 1;
    localparam int STAT_READY = 2;
    localparam int STAT_FUSE = 3;
    // Pins dedicated to power_down_input_a / power_down_input_b
    localparam int PD_A_PIN = 0;
    localparam int PD_B_PIN = 1;
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] RPWR_RST = 8'h00;
    localparam logic [7:0] SLEW_RST = 8'h00;
    localparam logic [7:0] OE_RST = 8'h00;
    localparam logic [15:0] SIG_RST = 16'h0000;
    localparam logic [7:0] OUT_POL = 8'h0F;
    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing
    localparam int CLK_NS = 20;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int IDLE_NS = 200;
    localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_ADDER_CYC = 1;
endpackage

// *** power_down_and_reset_control.sv ***
// Power-down, standby, keeper, slew and reset control with AXI4-Lite access
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module power_down_and_reset_control (
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic [5:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [5:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [7:0] PIN_I,
    output logic [7:0] PIN_O,
    output logic [7:0] PIN_OE_O,
    output logic [7:0] PIN_KEEP_OE_O,
    output logic [7:0] SLEW_FAST_O,
    output logic [7:0] FOLDBACK_O,
    output logic POWER_DOWN_O,
    output logic STANDBY_O
);
    localparam logic [7:0] SETTLE_C = 8'(pd_rst_pkg::SETTLE_CYC);
    localparam logic [7:0] IDLE_C = 8'(pd_rst_pkg::IDLE_CYC);
    localparam logic [7:0] PD_MASK = 8'h03;

    logic [2:0] ctrl_reg;
    logic [7:0] rpwr_reg;
    logic [7:0] slew_reg;
    logic [7:0] oe_reg;
    logic [15:0] sig_reg;
    logic fuse_reg;
    logic ready_reg;
    logic [7:0] settle_reg;
    logic [7:0] idle_reg;
    logic [7:0] pin_in_reg;
    logic [7:0] keep_lvl_reg;
    logic [7:0] mc_reg;
    logic [7:0] rp_stage_reg;
    logic [5:0] aw_addr_reg;
    logic aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_have_reg;
    logic [5:0] rd_addr_reg;
    logic pd_act;
    logic run;
    logic [7:0] pd_pins;
    logic [7:0] mc_calc;
    logic [7:0] mc_next;
    logic [31:0] wmask;
    logic wr_go;
    logic [31:0] rd_data;
    logic rd_err;

    //------------------------------------------------------------
    // Power-down detection
    //------------------------------------------------------------
    assign pd_act = ctrl_reg[pd_rst_pkg::CTRL_PD_EN] &
        (PIN_I[pd_rst_pkg::PD_A_PIN] | PIN_I[pd_rst_pkg::PD_B_PIN]);
    assign run = ready_reg & ~pd_act;
    assign pd_pins = ctrl_reg[pd_rst_pkg::CTRL_PD_EN] ? PD_MASK : 8'h00;

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            POWER_DOWN_O <= 1'b0;
        end else begin
            POWER_DOWN_O <= pd_act;
        end
    end

    //------------------------------------------------------------
    // Reset settling
    //------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            settle_reg <= 8'h00;
            ready_reg <= 1'b0;
        end else if (!ready_reg) begin
            settle_reg <= settle_reg + 8'h01;
            ready_reg <= (settle_reg == SETTLE_C - 8'h01);
        end
    end

    //------------------------------------------------------------
    // Pin sampling and keeper level
    //------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_in_reg <= 8'h00;
            keep_lvl_reg <= 8'h00;
        end else if (run) begin
            pin_in_reg <= PIN_I & ~pd_pins;
            keep_lvl_reg <= PIN_I;
        end
    end

    //------------------------------------------------------------
    // Macrocell array
    //------------------------------------------------------------
    assign mc_calc = pin_in_reg ^ {mc_reg[6:0], mc_reg[7]};
    assign mc_next = (rpwr_reg & rp_stage_reg) | (~rpwr_reg & mc_calc);

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mc_reg <= 8'h00;
            rp_stage_reg <= 8'h00;
            FOLDBACK_O <= 8'h00;
        end else if (run) begin
            rp_stage_reg <= mc_calc;
            mc_reg <= mc_next;
            FOLDBACK_O <= ~mc_calc;
        end
    end

    //------------------------------------------------------------
    // Output drivers
    //------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            PIN_O <= pd_rst_pkg::OUT_POL;
            PIN_OE_O <= 8'h00;
            PIN_KEEP_OE_O <= 8'h00;
        end else if (run) begin
            PIN_O <= (oe_reg & (mc_reg ^ pd_rst_pkg::OUT_POL)) | (~oe_reg & keep_lvl_reg);
            PIN_OE_O <= oe_reg & ~pd_pins;
            PIN_KEEP_OE_O <= {8{ctrl_reg[pd_rst_pkg::CTRL_KEEP_EN]}} & ~oe_reg & ~pd_pins;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SLEW_FAST_O <= pd_rst_pkg::SLEW_RST;
        end else begin
            SLEW_FAST_O <= slew_reg;
        end
    end

    //------------------------------------------------------------
    // Automatic standby
    //------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            idle_reg <= 8'h00;
            STANDBY_O <= 1'b0;
        end else if (!ctrl_reg[pd_rst_pkg::CTRL_SB_EN] || !run || PIN_I != keep_lvl_reg) begin
            idle_reg <= 8'h00;
            STANDBY_O <= 1'b0;
        end else if (idle_reg != IDLE_C) begin
            idle_reg <= idle_reg + 8'h01;
        end else begin
            STANDBY_O <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite write channel
    //------------------------------------------------------------
    assign wr_go = aw_have_reg & w_have_reg & ~S_AXI_BVALID_O;
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_addr_reg <= 6'h00;
            aw_have_reg <= 1'b0;
            S_AXI_AWREADY_O <= 1'b1;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_addr_reg <= S_AXI_AWADDR_I;
            aw_have_reg <= 1'b1;
            S_AXI_AWREADY_O <= 1'b0;
        end else if (wr_go) begin
            aw_have_reg <= 1'b0;
        end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_AWREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            w_have_reg <= 1'b0;
            S_AXI_WREADY_O <= 1'b1;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I;
            w_have_reg <= 1'b1;
            S_AXI_WREADY_O <= 1'b0;
        end else if (wr_go) begin
            w_have_reg <= 1'b0;
        end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_WREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= pd_rst_pkg::RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= (aw_addr_reg > pd_rst_pkg::CFG_OFS || aw_addr_reg[1:0] != 2'h0) ?
                pd_rst_pkg::RESP_SLVERR : pd_rst_pkg::RESP_OKAY;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_reg <= pd_rst_pkg::CTRL_RST;
            rpwr_reg <= pd_rst_pkg::RPWR_RST;
            slew_reg <= pd_rst_pkg::SLEW_RST;
            oe_reg <= pd_rst_pkg::OE_RST;
            sig_reg <= pd_rst_pkg::SIG_RST;
        end else if (wr_go) begin
            unique case (aw_addr_reg)
                pd_rst_pkg::CTRL_OFS: begin
                    ctrl_reg <= (ctrl_reg & ~wmask[2:0]) | (w_data_reg[2:0] & wmask[2:0]);
                end
                pd_rst_pkg::RPWR_OFS: begin
                    rpwr_reg <= (rpwr_reg & ~wmask[7:0]) | (w_data_reg[7:0] & wmask[7:0]);
                end
                pd_rst_pkg::SLEW_OFS: begin
                    slew_reg <= (slew_reg & ~wmask[7:0]) | (w_data_reg[7:0] & wmask[7:0]);
                end
                pd_rst_pkg::OE_OFS: begin
                    oe_reg <= (oe_reg & ~wmask[7:0]) | (w_data_reg[7:0] & wmask[7:0]);
                end
                pd_rst_pkg::SIG_OFS: begin
                    sig_reg <= (sig_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fuse_reg <= 1'b0;
        end else if (wr_go && aw_addr_reg == pd_rst_pkg::FUSE_OFS && w_strb_reg[0] && w_data_reg[0]) begin
            fuse_reg <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite read channel
    //------------------------------------------------------------
    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        unique case (S_AXI_ARADDR_I)
            pd_rst_pkg::CTRL_OFS: rd_data[2:0] = ctrl_reg;
            pd_rst_pkg::RPWR_OFS: rd_data[7:0] = rpwr_reg;
            pd_rst_pkg::SLEW_OFS: rd_data[7:0] = slew_reg;
            pd_rst_pkg::OE_OFS: rd_data[7:0] = oe_reg;
            pd_rst_pkg::SIG_OFS: rd_data[15:0] = sig_reg;
            pd_rst_pkg::FUSE_OFS: rd_data[0] = fuse_reg;
            pd_rst_pkg::STAT_OFS: rd_data[3:0] = {fuse_reg, ready_reg, STANDBY_O, POWER_DOWN_O};
            pd_rst_pkg::MCELL_OFS: rd_data[15:0] = {FOLDBACK_O, mc_reg};
            pd_rst_pkg::CFG_OFS: begin
                if (fuse_reg) begin
                    rd_err = 1'b1;
                end else begin
                    rd_data = {oe_reg, slew_reg, rpwr_reg, 5'h00, ctrl_reg};
                end
            end
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= pd_rst_pkg::RESP_OKAY;
            rd_addr_reg <= 6'h00;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= rd_data;
            S_AXI_RRESP_O <= rd_err ? pd_rst_pkg::RESP_SLVERR : pd_rst_pkg::RESP_OKAY;
            rd_addr_reg <= S_AXI_ARADDR_I;
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    AST_PD_ENTER: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ctrl_reg[0] && (PIN_I[0] || PIN_I[1]) |=> POWER_DOWN_O)
        else $error("Power-down not entered");
    AST_PD_FREEZE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        pd_act |=> $stable(mc_reg) && $stable(FOLDBACK_O))
        else $error("Internal state moved in power-down");
    AST_PD_OUT: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        pd_act |=> $stable(PIN_O) && $stable(PIN_OE_O))
        else $error("Outputs moved in power-down");
    AST_PD_PINS: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        pd_act ##1 !pd_act && ready_reg |=> pin_in_reg == ($past(PIN_I) & ~$past(pd_pins)))
        else $error("Pins not followed after power-down");
    AST_PD_DEDIC: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ctrl_reg[0] && run |=> !PIN_OE_O[0] && !PIN_OE_O[1] && !pin_in_reg[0] && !pin_in_reg[1])
        else $error("Power-down pin used as logic");
    AST_STANDBY: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        STANDBY_O && PIN_I != keep_lvl_reg |=> !STANDBY_O)
        else $error("Standby not left on activity");
    AST_RP_DELAY: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        run && rpwr_reg[2] |=> mc_reg[2] == $past(rp_stage_reg[2]))
        else $error("Reduced-power path not delayed");
    AST_SLEW: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        $stable(slew_reg) |=> SLEW_FAST_O == $past(slew_reg))
        else $error("Slew output wrong");
    AST_INIT: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        !ready_reg |-> mc_reg == 8'h00 && PIN_O == pd_rst_pkg::OUT_POL)
        else $error("Registers not initialized");
    AST_KEEP: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        run && ctrl_reg[2] && !oe_reg[5] |=> PIN_KEEP_OE_O[5] && PIN_O[5] == $past(keep_lvl_reg[5]))
        else $error("Keeper level lost");
    AST_FUSE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == pd_rst_pkg::CFG_OFS && fuse_reg
        |=> S_AXI_RRESP_O == pd_rst_pkg::RESP_SLVERR && S_AXI_RDATA_O == 32'h00000000)
        else $error("Readback not refused");
    AST_SIG: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        S_AXI_RVALID_O && rd_addr_reg == pd_rst_pkg::SIG_OFS |-> S_AXI_RRESP_O == pd_rst_pkg::RESP_OKAY)
        else $error("Signature read refused");
    AST_RESUME: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        pd_act ##1 run |-> mc_reg == $past(mc_reg))
        else $error("State lost on power-down exit");
    AST_FOLD: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        ctrl_reg[pd_rst_pkg::CTRL_PD_EN] && run |=>
        FOLDBACK_O[1:0] == ~($past(pin_in_reg[1:0]) ^ {$past(mc_reg[0]), $past(mc_reg[7])}))
        else $error("Foldback lost behind power-down pin");
endmodule

// *** pd_board_model.sv ***
// Board-side model that drives and resolves the pin wires
`timescale 1ns/1ps
module pd_board_model (
    input wire logic clk_i,
    input wire logic [7:0] drv_val_i,
    input wire logic [7:0] drv_en_i,
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] keep_oe_i,
    output logic [7:0] level_o
);
    //------------------------------------------------------------
    // Wire resolution
    //------------------------------------------------------------
    logic [7:0] float_reg;

    // Undriven wire keeps changing so no stale level survives
    always_ff @(posedge clk_i) begin
        float_reg <= ~level_o;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_i[i]) begin
                level_o[i] = pin_o_i[i];
            end else if (drv_en_i[i]) begin
                level_o[i] = drv_val_i[i];
            end else if (keep_oe_i[i]) begin
                level_o[i] = pin_o_i[i];
            end else begin
                level_o[i] = float_reg[i];
            end
        end
    end
endmodule

// *** power_down_and_reset_control_tb.sv ***
// Self-checking testbench for the power-down and reset control block
`timescale 1ns/1ps
module power_down_and_reset_control_tb;
    //------------------------------------------------------------
    // Signals
    //------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [7:0] drv_val = 8'h00, drv_en = 8'hFF;
    logic awready, wready, bvalid, arready, rvalid, pd, sb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] pin_lvl, pin_o, pin_oe, keep_oe, slew, fold;
    int n_mismatch = 0;
    int n_tests = 0;

    always #10 clk = ~clk;

    power_down_and_reset_control DUT (
        .REF_CLK_I(clk), .RSTN_I(rstn),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .PIN_I(pin_lvl), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PIN_KEEP_OE_O(keep_oe),
        .SLEW_FAST_O(slew), .FOLDBACK_O(fold), .POWER_DOWN_O(pd), .STANDBY_O(sb)
    );

    pd_board_model board (
        .clk_i(clk), .drv_val_i(drv_val), .drv_en_i(drv_en), .pin_o_i(pin_o),
        .pin_oe_i(pin_oe), .keep_oe_i(keep_oe), .level_o(pin_lvl)
    );

    //------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------
    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // Ready flags are registered, so the negedge value is the edge value
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            r = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) break;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clk);
            ah = arvalid && arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
            if (rh) break;
        end
        rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk(d, exp);
        chk(r, er);
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        int k;
        @(negedge clk);
        chk(pin_o, pd_rst_pkg::OUT_POL);
        chk({pin_oe, keep_oe, slew, fold}, 32'h00000000);
        chk({pd, sb}, 2'h0);
        rd_chk(pd_rst_pkg::CTRL_OFS, 32'h00000000, pd_rst_pkg::RESP_OKAY);
        rd_chk(pd_rst_pkg::SIG_OFS, 32'h00000000, pd_rst_pkg::RESP_OKAY);
        // Poll the status register until the ready flag shows settling has ended
        for (k = 0; k < 40; k++) begin
            axi_read(pd_rst_pkg::STAT_OFS, d, r);
            if (d[pd_rst_pkg::STAT_READY] === 1'b1) break;
        end
        chk(d[pd_rst_pkg::STAT_READY], 1'b1);
    endtask

    task automatic t_slew_rpwr();
        logic [1:0] r;
        axi_write(pd_rst_pkg::SLEW_OFS, 32'h000000A5, r);
        @(negedge clk);
        chk(slew, 8'hA5);
        axi_write(pd_rst_pkg::RPWR_OFS, 32'h0000003C, r);
        rd_chk(pd_rst_pkg::RPWR_OFS, 32'h0000003C, pd_rst_pkg::RESP_OKAY);
    endtask

    task automatic t_pd();
        logic [31:0] snap;
        logic [1:0] r;
        logic [7:0] p0;
        int k;
        @(posedge clk);
        drv_val <= 8'hA8;
        axi_write(pd_rst_pkg::SIG_OFS, 32'h0000BEEF, r);
        axi_write(pd_rst_pkg::CTRL_OFS, 32'h00000001, r);
        axi_write(pd_rst_pkg::OE_OFS, 32'h000000FF, r);
        repeat (2) @(negedge clk);
        chk(pin_oe, 8'hFC);
        axi_write(pd_rst_pkg::OE_OFS, 32'h00000000, r);
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            drv_val <= 8'hA8 | (8'h01 << k);
            repeat (2) @(negedge clk);
            chk(pd, 1'b1);
            axi_read(pd_rst_pkg::MCELL_OFS, snap, r);
            @(negedge clk);
            p0 = pin_o;
            @(posedge clk);
            drv_val <= drv_val ^ 8'hF0;
            repeat (5) @(posedge clk);
            rd_chk(pd_rst_pkg::MCELL_OFS, snap, pd_rst_pkg::RESP_OKAY);
            chk(pin_o, p0);
            chk(pd, 1'b1);
            @(posedge clk);
            drv_val <= 8'h58;
            repeat (2) @(negedge clk);
            chk(pd, 1'b0);
        end
        rd_chk(pd_rst_pkg::CTRL_OFS, 32'h00000001, pd_rst_pkg::RESP_OKAY);
        rd_chk(pd_rst_pkg::SIG_OFS, 32'h0000BEEF, pd_rst_pkg::RESP_OKAY);
    endtask

    task automatic t_standby();
        logic [1:0] r;
        axi_write(pd_rst_pkg::CTRL_OFS, 32'h00000002, r);
        repeat (pd_rst_pkg::IDLE_CYC + 3) @(negedge clk);
        chk(sb, 1'b1);
        @(posedge clk);
        drv_val <= drv_val ^ 8'h04;
        repeat (2) @(negedge clk);
        chk(sb, 1'b0);
        repeat (pd_rst_pkg::IDLE_CYC - 2) @(negedge clk);
        chk(sb, 1'b0);
    endtask

    task automatic t_keeper();
        logic [1:0] r;
        logic v;
        int k;
        axi_write(pd_rst_pkg::CTRL_OFS, 32'h00000004, r);
        for (k = 0; k < 2; k++) begin
            v = (k == 0);
            @(posedge clk);
            drv_val[3] <= v;
            repeat (3) @(posedge clk);
            drv_en <= 8'hF7;
            repeat (3) @(negedge clk);
            chk({keep_oe[3], pin_o[3], pin_lvl[3]}, {1'b1, v, v});
            @(posedge clk);
            drv_en <= 8'hFF;
        end
    endtask

    task automatic t_bus_err();
        logic [1:0] r;
        axi_write(6'h24, 32'h00000001, r);
        chk(r, pd_rst_pkg::RESP_SLVERR);
        rd_chk(6'h24, 32'h00000000, pd_rst_pkg::RESP_SLVERR);
    endtask

    task automatic t_fuse();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(pd_rst_pkg::CFG_OFS, d, r);
        chk(r, pd_rst_pkg::RESP_OKAY);
        axi_write(pd_rst_pkg::FUSE_OFS, 32'h00000001, r);
        rd_chk(pd_rst_pkg::CFG_OFS, 32'h00000000, pd_rst_pkg::RESP_SLVERR);
        rd_chk(pd_rst_pkg::SIG_OFS, 32'h0000BEEF, pd_rst_pkg::RESP_OKAY);
        axi_read(pd_rst_pkg::STAT_OFS, d, r);
        chk(d[pd_rst_pkg::STAT_FUSE], 1'b1);
    endtask

    //------------------------------------------------------------
    // Sequence and watchdog
    //------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_slew_rpwr();
        t_pd();
        t_standby();
        t_keeper();
        t_bus_err();
        t_fuse();
        test_done();
    end

    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
endmodule
